// ===== core/aix_channel.sv
// aux input three channel: supply fault detector, logic input and register file
module aix_channel (
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic [7:0] adc_code_i,
   input  wire logic       logic_pin_i,
   output logic            over_flag_o,
   output logic            under_flag_o,
   output logic            logic_out_o,
   output logic            fault_o,
   output logic            warning_o
);
   import aix_pkg::*;

   typedef enum logic [1:0] {GF_IDLE = 2'b00, GF_WAIT = 2'b01} aix_gf_state_t;

   function automatic logic [8:0] aix_add9(input logic [7:0] a, input logic [4:0] b);
      return {1'b0, a} + {4'h0, b};
   endfunction

   logic [7:0] ov_limit_r;
   logic [4:0] ov_hyst_r;
   logic [7:0] uv_limit_r;
   logic [4:0] uv_hyst_r;
   logic [4:0] sfd_cfg_r;
   logic [1:0] func_sel_r;
   logic [6:0] gpi_cfg_r;

   ////////////////////////////////////////////////////////////////////////////
   // register file
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ov_limit_r <= RST_OV_LIMIT;
         ov_hyst_r  <= RST_HYST;
         uv_limit_r <= RST_UV_LIMIT;
         uv_hyst_r  <= RST_HYST;
         sfd_cfg_r  <= RST_SFD_CFG;
         func_sel_r <= RST_FUNC_SEL;
         gpi_cfg_r  <= RST_GPI_CFG;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            ADDR_OV_LIMIT: ov_limit_r <= reg_wdata_i;
            ADDR_OV_HYST:  ov_hyst_r  <= reg_wdata_i[HYST_MSB:0];
            ADDR_UV_LIMIT: uv_limit_r <= reg_wdata_i;
            ADDR_UV_HYST:  uv_hyst_r  <= reg_wdata_i[HYST_MSB:0];
            ADDR_SFD_CFG:  sfd_cfg_r  <= reg_wdata_i[4:0];
            ADDR_FUNC_SEL: func_sel_r <= reg_wdata_i[1:0];
            ADDR_GPI_CFG:  gpi_cfg_r  <= reg_wdata_i[6:0];
            default: ;
         endcase
      end
   end

   // unused bits read as zero, unmapped offsets read zero
   always_comb begin
      unique case (reg_addr_i)
         ADDR_OV_LIMIT: reg_rdata_o = ov_limit_r;
         ADDR_OV_HYST:  reg_rdata_o = {3'h0, ov_hyst_r};
         ADDR_UV_LIMIT: reg_rdata_o = uv_limit_r;
         ADDR_UV_HYST:  reg_rdata_o = {3'h0, uv_hyst_r};
         ADDR_SFD_CFG:  reg_rdata_o = {3'h0, sfd_cfg_r};
         ADDR_FUNC_SEL: reg_rdata_o = {6'h00, func_sel_r};
         ADDR_GPI_CFG:  reg_rdata_o = {1'b0, gpi_cfg_r};
         default:       reg_rdata_o = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // supply fault detector compare with hysteresis
   logic [1:0] ftype;
   logic [8:0] ov_eff;
   logic [8:0] uv_eff;
   logic       ov_raw;
   logic       uv_raw;
   logic       ov_r;
   logic       uv_r;

   assign ftype = sfd_cfg_r[1:0];

   always_comb begin
      ov_eff = {1'b0, ov_limit_r};
      uv_eff = {1'b0, uv_limit_r};
      if (ov_r) begin
         ov_eff = {1'b0, ov_limit_r} - {4'h0, ov_hyst_r};
         if (ov_hyst_r > ov_limit_r) ov_eff = 9'h000;
      end
      if (uv_r) begin
         uv_eff = aix_add9(uv_limit_r, uv_hyst_r);
      end
      ov_raw = ({1'b0, adc_code_i} > ov_eff) &&
               ((ftype == FT_OVER) || (ftype == FT_EITHER));
      uv_raw = ({1'b0, adc_code_i} < uv_eff) &&
               ((ftype == FT_UNDER) || (ftype == FT_EITHER));
   end

   // detector glitch filter on each flag
   aix_cnt_t ov_cnt_r;
   aix_cnt_t uv_cnt_r;
   aix_cnt_t sfd_gf;
   assign sfd_gf = aix_gf_cycles(sfd_cfg_r[SFD_GF_LSB +: 3]);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ov_r     <= 1'b0;
         ov_cnt_r <= '0;
      end else if (ov_raw == ov_r) begin
         ov_cnt_r <= '0;
      end else if (ov_cnt_r >= sfd_gf) begin
         ov_r     <= ov_raw;
         ov_cnt_r <= '0;
      end else begin
         ov_cnt_r <= ov_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         uv_r     <= 1'b0;
         uv_cnt_r <= '0;
      end else if (uv_raw == uv_r) begin
         uv_cnt_r <= '0;
      end else if (uv_cnt_r >= sfd_gf) begin
         uv_r     <= uv_raw;
         uv_cnt_r <= '0;
      end else begin
         uv_cnt_r <= uv_cnt_r + 1'b1;
      end
   end

   assign over_flag_o  = ov_r;
   assign under_flag_o = uv_r;

   ////////////////////////////////////////////////////////////////////////////
   // logic input: synchroniser, invert, glitch filter
   logic [2:0] pin_sync_r;
   logic       pin_stable_r;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_sync_r   <= 3'h0;
         pin_stable_r <= 1'b0;
      end else begin
         pin_sync_r <= {pin_sync_r[1:0], logic_pin_i};
         if (pin_sync_r[1] == pin_sync_r[2]) pin_stable_r <= pin_sync_r[2];
      end
   end

   logic gpi_in;
   assign gpi_in = pin_stable_r ^ gpi_cfg_r[GPI_INV_BIT];

   aix_gf_state_t gf_state_r;
   aix_cnt_t      gpi_cnt_r;
   logic          gpi_filt_r;
   aix_cnt_t      gpi_gf;
   assign gpi_gf = aix_gf_cycles(gpi_cfg_r[2:0]);

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         gf_state_r <= GF_IDLE;
         gpi_cnt_r  <= '0;
         gpi_filt_r <= 1'b0;
      end else begin
         unique case (gf_state_r)
            GF_IDLE: begin
               gpi_cnt_r <= '0;
               if (gpi_in != gpi_filt_r) begin
                  if (gpi_gf == '0) gpi_filt_r <= gpi_in;
                  else gf_state_r <= GF_WAIT;
               end
            end
            GF_WAIT: begin
               if (gpi_in == gpi_filt_r) begin
                  gf_state_r <= GF_IDLE;
               end else if (gpi_cnt_r + 1'b1 >= gpi_gf) begin
                  gpi_filt_r <= gpi_in;
                  gf_state_r <= GF_IDLE;
               end else begin
                  gpi_cnt_r <= gpi_cnt_r + 1'b1;
               end
            end
            default: gf_state_r <= GF_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // level or edge detection with pulse stretch
   logic     filt_d_r;
   logic     pulse_r;
   aix_cnt_t pulse_cnt_r;
   aix_cnt_t pulse_len;
   logic     edge_hit;

   always_comb begin
      pulse_len = CNT_W'(PULSE_CYC0);
      unique case (gpi_cfg_r[GPI_PULS_LSB +: 2])
         2'h0: pulse_len = CNT_W'(PULSE_CYC0);
         2'h1: pulse_len = CNT_W'(PULSE_CYC1);
         2'h2: pulse_len = CNT_W'(PULSE_CYC2);
         2'h3: pulse_len = CNT_W'(PULSE_CYC3);
      endcase
   end

   // qualifying edge is an inactive-to-active change of the filtered input
   assign edge_hit = gpi_filt_r && !filt_d_r;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         filt_d_r    <= 1'b0;
         pulse_r     <= 1'b0;
         pulse_cnt_r <= '0;
      end else begin
         filt_d_r <= gpi_filt_r;
         if (edge_hit && gpi_cfg_r[GPI_TYPE_BIT]) begin
            pulse_r     <= 1'b1;
            pulse_cnt_r <= pulse_len - 1'b1;
         end else if (pulse_cnt_r != '0) begin
            pulse_cnt_r <= pulse_cnt_r - 1'b1;
         end else begin
            pulse_r <= 1'b0;
         end
      end
   end

   logic gpi_active;
   assign gpi_active = gpi_cfg_r[GPI_TYPE_BIT] ? pulse_r : gpi_filt_r;
   assign logic_out_o = gpi_active;

   ////////////////////////////////////////////////////////////////////////////
   // function routing
   logic sfd_any;
   assign sfd_any = ov_r | uv_r;

   always_comb begin
      fault_o   = 1'b0;
      warning_o = 1'b0;
      unique case (func_sel_r)
         FS_SFD:  fault_o = sfd_any;
         FS_GPI:  fault_o = gpi_active;
         FS_BOTH: begin
            fault_o   = gpi_active;
            warning_o = sfd_any;
         end
         default: ;
      endcase
   end

endmodule

// ===== shared/aix_pkg.sv
// constants and types for the aux input three fault and logic input channel
package aix_pkg;

   localparam int unsigned CLK_HZ = 20_000_000;

   // register offsets
   localparam logic [7:0] ADDR_OV_LIMIT  = 8'h38;
   localparam logic [7:0] ADDR_OV_HYST   = 8'h39;
   localparam logic [7:0] ADDR_UV_LIMIT  = 8'h3a;
   localparam logic [7:0] ADDR_UV_HYST   = 8'h3b;
   localparam logic [7:0] ADDR_SFD_CFG   = 8'h3c;
   localparam logic [7:0] ADDR_FUNC_SEL  = 8'h3d;
   localparam logic [7:0] ADDR_GPI_CFG   = 8'h3e;

   // field positions
   localparam int unsigned HYST_MSB      = 4;
   localparam int unsigned SFD_GF_LSB    = 2;
   localparam int unsigned GPI_INV_BIT   = 6;
   localparam int unsigned GPI_TYPE_BIT  = 5;
   localparam int unsigned GPI_PULS_LSB  = 3;

   // reset values
   localparam logic [7:0] RST_OV_LIMIT  = 8'hff;
   localparam logic [4:0] RST_HYST      = 5'h00;
   localparam logic [7:0] RST_UV_LIMIT  = 8'h00;
   localparam logic [4:0] RST_SFD_CFG   = 5'h03;
   localparam logic [1:0] RST_FUNC_SEL  = 2'h0;
   localparam logic [6:0] RST_GPI_CFG   = 7'h00;

   // fault type and function select codes
   localparam logic [1:0] FT_OVER   = 2'h0;
   localparam logic [1:0] FT_EITHER = 2'h1;
   localparam logic [1:0] FT_UNDER  = 2'h2;
   localparam logic [1:0] FS_SFD    = 2'h0;
   localparam logic [1:0] FS_GPI    = 2'h1;
   localparam logic [1:0] FS_BOTH   = 2'h2;

   // times in microseconds and derived cycle counts
   localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int unsigned PULSE_US0 = 10;
   localparam int unsigned PULSE_US1 = 100;
   localparam int unsigned PULSE_US2 = 1000;
   localparam int unsigned PULSE_US3 = 10000;
   localparam int unsigned GF_US1 = 5;
   localparam int unsigned GF_US2 = 10;
   localparam int unsigned GF_US3 = 20;
   localparam int unsigned GF_US4 = 30;
   localparam int unsigned GF_US5 = 50;
   localparam int unsigned GF_US6 = 75;
   localparam int unsigned GF_US7 = 100;
   localparam int unsigned PULSE_CYC0 = PULSE_US0 * CYC_PER_US;
   localparam int unsigned PULSE_CYC1 = PULSE_US1 * CYC_PER_US;
   localparam int unsigned PULSE_CYC2 = PULSE_US2 * CYC_PER_US;
   localparam int unsigned PULSE_CYC3 = PULSE_US3 * CYC_PER_US;
   localparam int unsigned GF_CYC1 = GF_US1 * CYC_PER_US;
   localparam int unsigned GF_CYC2 = GF_US2 * CYC_PER_US;
   localparam int unsigned GF_CYC3 = GF_US3 * CYC_PER_US;
   localparam int unsigned GF_CYC4 = GF_US4 * CYC_PER_US;
   localparam int unsigned GF_CYC5 = GF_US5 * CYC_PER_US;
   localparam int unsigned GF_CYC6 = GF_US6 * CYC_PER_US;
   localparam int unsigned GF_CYC7 = GF_US7 * CYC_PER_US;
   localparam int unsigned CNT_W = 18;

   typedef logic [CNT_W-1:0] aix_cnt_t;

   // glitch delay in cycles for a 3-bit code
   function automatic aix_cnt_t aix_gf_cycles(input logic [2:0] code);
      aix_cnt_t c;
      c = '0;
      unique case (code)
         3'h0: c = '0;
         3'h1: c = CNT_W'(GF_CYC1);
         3'h2: c = CNT_W'(GF_CYC2);
         3'h3: c = CNT_W'(GF_CYC3);
         3'h4: c = CNT_W'(GF_CYC4);
         3'h5: c = CNT_W'(GF_CYC5);
         3'h6: c = CNT_W'(GF_CYC6);
         3'h7: c = CNT_W'(GF_CYC7);
      endcase
      return c;
   endfunction

endpackage

// ===== sim/aix_channel_assertions.sv
// port checker of the aux input three channel
module aix_channel_assertions (
   input wire logic       clk_i,
   input wire logic       sys_rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic       reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] adc_code_i,
   input wire logic       logic_pin_i,
   input wire logic       over_flag_o,
   input wire logic       under_flag_o,
   input wire logic       logic_out_o,
   input wire logic       fault_o,
   input wire logic       warning_o
);
   timeunit 1ns;
   timeprecision 1ns;
   import aix_pkg::*;
   logic [7:0] ovl_r;
   logic [4:0] cfg_r;
   logic [1:0] sel_r;
   logic       det;
   assign det = over_flag_o | under_flag_o;
   // mirrors of the settings that the checks depend on
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ovl_r <= RST_OV_LIMIT;
         cfg_r <= RST_SFD_CFG;
         sel_r <= RST_FUNC_SEL;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ADDR_OV_LIMIT) ovl_r <= reg_wdata_i;
         if (reg_addr_i == ADDR_SFD_CFG) cfg_r <= reg_wdata_i[4:0];
         if (reg_addr_i == ADDR_FUNC_SEL) sel_r <= reg_wdata_i[1:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   chk_over_rise: assert property ((cfg_r[4:2] == 3'h0 && cfg_r[1:0] < 2'h2 && !reg_wr_i
      && !over_flag_o && adc_code_i > ovl_r) |=> over_flag_o) else $error("over flag late");
   chk_type_off: assert property ((cfg_r[1:0] == 2'h3 && !reg_wr_i && !det) |=> !det)
      else $error("flag while detector off");
   chk_under_block: assert property ((cfg_r[1:0] == FT_OVER && !reg_wr_i
      && !under_flag_o) |=> !under_flag_o) else $error("under flag in over-only mode");
   chk_over_block: assert property ((cfg_r[1:0] == FT_UNDER && !reg_wr_i && !over_flag_o)
      |=> !over_flag_o) else $error("over flag in under-only mode");
   chk_route_sfd: assert property (sel_r == FS_SFD |-> fault_o == det && !warning_o)
      else $error("detector routing wrong");
   chk_route_gpi: assert property (sel_r == FS_GPI
      |-> fault_o == logic_out_o && !warning_o) else $error("logic routing wrong");
   chk_route_both: assert property (sel_r == FS_BOTH
      |-> fault_o == logic_out_o && warning_o == det) else $error("dual routing wrong");
   chk_unmapped_read: assert property ((reg_addr_i < 8'h38 || reg_addr_i > 8'h3e)
      |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
   chk_limit_readback: assert property (reg_addr_i == ADDR_OV_LIMIT |-> reg_rdata_o == ovl_r)
      else $error("over limit readback wrong");
endmodule
bind aix_channel aix_channel_assertions i_aix_channel_assertions (.clk_i, .sys_rst_i,
   .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rdata_o, .adc_code_i, .logic_pin_i,
   .over_flag_o, .under_flag_o, .logic_out_o, .fault_o, .warning_o);

// ===== sim/aix_channel_tb_top.sv
// self-checking bench of the aux input three channel
module aix_channel_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import aix_pkg::*;
   logic       clk_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic       reg_wr_i = 1'b0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [7:0] level = 8'h60;
   logic       pin = 1'b0;
   logic [1:0] sel = 2'h0;
   logic [7:0] reg_rdata_o, adc_code_i, rd, v;
   logic       logic_pin_i, over_flag_o, under_flag_o, logic_out_o, fault_o, warning_o;
   int         failures = 0;
   int         check_count = 0;
   int         n;
   logic [7:0] rst_tab [7] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
   logic [7:0] msk_tab [7] = '{8'hff, 8'h1f, 8'hff, 8'h1f, 8'h1f, 8'h03, 8'h7f};
   logic [7:0] cfg_tab [7] = '{8'h80, 8'h05, 8'h40, 8'h03, 8'h00, 8'h00, 8'h00};
   always #25 clk_i = ~clk_i;
   aix_rail_model i_aix_rail_model (.clk_i, .level_i(level), .pin_i(pin),
      .adc_code_o(adc_code_i), .logic_pin_o(logic_pin_i));
   aix_channel i_aix_channel (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
      .reg_rdata_o, .adc_code_i, .logic_pin_i, .over_flag_o, .under_flag_o, .logic_out_o,
      .fault_o, .warning_o);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [4:0] exp_outs(input logic ov, uv, lo, input logic [1:0] s);
      logic [1:0] fw;
      fw = s == FS_SFD ? {ov | uv, 1'b0} : s == FS_GPI ? {lo, 1'b0} :
           s == FS_BOTH ? {lo, ov | uv} : 2'b00;
      return {ov, uv, lo, fw};
   endfunction
   function automatic int pulse_len(input int p);
      return p == 0 ? PULSE_CYC0 : p == 1 ? PULSE_CYC1 : PULSE_CYC2;
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t %s got %0h expected %0h", $time, msg, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rdb(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i <= a;
      cyc(1);
      d = reg_rdata_o;
   endtask
   task automatic set(input logic [7:0] lv, input logic pv, input int k);
      @(posedge clk_i);
      level <= lv;
      pin   <= pv;
      cyc(k);
   endtask
   task automatic ex(input logic ov, uv, lo, input string msg);
      chk({27'h0, over_flag_o, under_flag_o, logic_out_o, fault_o, warning_o},
          {27'h0, exp_outs(ov, uv, lo, sel)}, msg);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      v = 8'($urandom(66));
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rdb(8'h38 + 8'(i), rd);
         chk(rd, rst_tab[i], "reset value");
      end
      for (int i = 0; i < 21; i++) begin
         v = 8'($urandom);
         wr(8'h38 + 8'(i % 7), v);
         rdb(8'h38 + 8'(i % 7), rd);
         chk(rd, v & msk_tab[i % 7], "readback");
      end
      wr(8'h3f, 8'hff);
      rdb(8'h3f, rd);
      chk(rd, 8'h00, "unmapped high");
      rdb(8'h37, rd);
      chk(rd, 8'h00, "unmapped low");
      // second reset clears pulse and filter state left behind by the random settings
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      cyc(1);
      ex(0, 0, 0, "outputs after reset");
      for (int i = 0; i < 7; i++) begin
         rdb(8'h38 + 8'(i), rd);
         chk(rd, rst_tab[i], "reset value again");
      end
      for (int i = 0; i < 7; i++) wr(8'h38 + 8'(i), cfg_tab[i]);
      set(8'h60, 1'b0, 12);
      $display("test registers done");
      set(8'h81, 1'b0, 4); ex(1, 0, 0, "over set");
      set(8'h7c, 1'b0, 4); ex(1, 0, 0, "over held");
      set(8'h7b, 1'b0, 4); ex(0, 0, 0, "over cleared");
      wr(8'h3c, {6'h0, FT_UNDER});
      set(8'h3f, 1'b0, 4); ex(0, 1, 0, "under set");
      set(8'h42, 1'b0, 4); ex(0, 1, 0, "under held");
      set(8'h43, 1'b0, 4); ex(0, 0, 0, "under cleared");
      for (int t = 0; t < 4; t++) begin
         wr(8'h3c, 8'(t));
         set(8'h90, 1'b0, 4); ex(t < 2, 0, 0, "type over");
         set(8'h10, 1'b0, 4); ex(0, t == 1 || t == 2, 0, "type under");
         set(8'h60, 1'b0, 4);
      end
      wr(8'h3c, 8'h04);
      set(8'h90, 1'b0, 60); set(8'h60, 1'b0, 120); ex(0, 0, 0, "short excursion");
      set(8'h90, 1'b0, 90); ex(0, 0, 0, "filter holding");
      cyc(20); ex(1, 0, 0, "filter passed");
      set(8'h60, 1'b0, 110);
      wr(8'h3c, 8'h00);
      set(8'h90, 1'b0, 4);
      for (int k = 0; k < 8; k++) begin
         if (k == 4) wr(8'h3e, 8'h40);
         if (k == 4) cyc(12);
         wr(8'h3d, 8'(k % 4));
         sel = 2'(k % 4);
         cyc(1); ex(1, 0, k >= 4, "routing");
      end
      set(8'h60, 1'b1, 12); ex(0, 0, 0, "inverted high pin");
      wr(8'h3d, 8'h00);
      sel = 2'h0;
      wr(8'h3e, 8'h01);
      set(8'h60, 1'b0, 12);
      set(8'h60, 1'b1, 60); set(8'h60, 1'b0, 120); ex(0, 0, 0, "pin glitch");
      set(8'h60, 1'b1, 120); ex(0, 0, 1, "pin held");
      set(8'h60, 1'b0, 120);
      $display("test detector and routing done");
      for (int p = 0; p < 3; p++) begin
         wr(8'h3e, 8'h20 | 8'(p << 3));
         set(8'h60, 1'b1, 1);
         n = 0;
         while (logic_out_o !== 1'b1 && n < 50) begin
            cyc(1);
            n++;
         end
         if (n == 50) begin
            failures++;
            finish_test();
         end
         n = 0;
         while (logic_out_o === 1'b1 && n < 30000) begin
            cyc(1);
            n++;
         end
         chk(n, pulse_len(p), "pulse length");
         if (n == 30000) finish_test();
         set(8'h60, 1'b0, 20);
      end
      $display("test edge pulses done");
      finish_test();
   end
endmodule

// ===== sim/aix_rail_model.sv
// behavioural source of the supervised rail code and the logic pin
module aix_rail_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] level_i,
   input  wire logic       pin_i,
   output logic      [7:0] adc_code_o,
   output logic            logic_pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial adc_code_o = 8'h00;
   initial logic_pin_o = 1'b0;
   // pin moves off the clock edge, as an unrelated source would
   always @(posedge clk_i) begin
      adc_code_o  <= level_i;
      logic_pin_o <= #7 pin_i;
   end
endmodule
